// *** kms_defs.vh ***
// Purpose: constants shared by the key matrix scanner files
// Assumes: 100 MHz clock, 16-bit user-bank words
// Notes: word addresses are 12-bit user word addresses
`ifndef KMS_DEFS_VH
`define KMS_DEFS_VH

// Clock rate
`define KMS_CLK_MHZ 100

// Word addresses
`define KMS_ADDR_SETTING 12'hF01
`define KMS_ADDR_RESULT0 12'hF10
`define KMS_ADDR_RESULT1 12'hF11
`define KMS_ADDR_RESULT2 12'hF12
`define KMS_ADDR_RESULT3 12'hF13

// Setting word fields
`define KMS_SET_EN_BIT 15
`define KMS_SET_TIME_HI 14
`define KMS_SET_TIME_LO 13
`define KMS_SET_LAST_HI 7
`define KMS_SET_LAST_LO 4
`define KMS_SET_RESET 16'h0000
`define KMS_SET_KEEP_MASK 16'hE0F0

// Result word fields
`define KMS_RES_COL_HI 11
`define KMS_RES_COL_LO 8
`define KMS_RES_ROW_HI 7
`define KMS_RES_ROW_LO 0
`define KMS_RES_RESET 16'h0000

// Column activate time codes
`define KMS_TIME_CODE_256 2'h0
`define KMS_TIME_CODE_512 2'h1
`define KMS_TIME_CODE_64 2'h2
`define KMS_TIME_CODE_128 2'h3

// Activate times in microseconds
`define KMS_ACT_64_US 64
`define KMS_ACT_128_US 128
`define KMS_ACT_256_US 256
`define KMS_ACT_512_US 512

// Reply window in milliseconds
`define KMS_REPLY_WINDOW_MS 20

// Command opcodes
`define KMS_OP_BLOCKERASE 8'hC8
`define KMS_OP_READ 8'hC2
`define KMS_READ_COUNT 8'h04

// Reply codes
`define KMS_ERR_NONE 8'h00
`define KMS_ERR_NO_KEY 8'h8E
`define KMS_ERR_LOW_POWER 8'h0B
`define KMS_ERR_OTHER 8'h00

// Scan limits
`define KMS_MAX_FOUND 3'd4
`define KMS_MAX_COLUMNS 5'd16

`endif

// *** kms_input_sync.v ***
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous to clock
// Notes: a change counts once stages two and three agree
`timescale 1ns/100ps
`include "kms_defs.vh"

module kms_input_sync #(
	parameter WIDTH = 9
) (
	// Clock and control
	input wire clock,
	input wire rst_n,
	input wire ce,
	// Data
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;
	reg [WIDTH-1:0] stable_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gBit
			always @(posedge clock) begin
				if (!rst_n) begin
					stage1_reg[i] <= 1'b0;
					stage2_reg[i] <= 1'b0;
					stage3_reg[i] <= 1'b0;
					stable_reg[i] <= 1'b0;
				end else if (ce) begin
					stage1_reg[i] <= asyncIn[i];
					stage2_reg[i] <= stage1_reg[i];
					stage3_reg[i] <= stage2_reg[i];
					// Only a value seen twice is taken
					if (stage2_reg[i] == stage3_reg[i]) begin
						stable_reg[i] <= stage3_reg[i];
					end
				end
			end
		end
	endgenerate

	assign syncOut = stable_reg;

endmodule // kms_input_sync

// *** kms_key_scanner.v ***
// Purpose: key matrix scanner behind the user-bank word interface
// Assumes: command decoder hands over Write, BlockErase and Read
// Notes: rows sampled in the last cycle of each column window
//
// Operation
// - Writing word F01h enables scanning; lost at every power cycle.
// - A Read of F01h returns the stored setting word.
// - Setting clears to 0000h on enable zero, power loss, low-power reset.
// - Setting bit 15 enables scanning; zero after reset.
// - Bits 14:13 pick column time: 256, 512, 64, 128 us.
// - BlockErase C8h to F10h with count last column plus one starts scan.
// - Only pressed columns stored, at most four, words F10h to F13h.
// - Scan with no pressed key answers error code 8Eh.
// - One to four pressed columns give the normal reply.
// - Supply drop during scan answers error code 0Bh.
// - Read C2h from F10h with count 04h returns four key words; the port returns one word per request at rdAddr.
// - Key word: zero, column index in 11:8, rows in 7:0.
// - Every scan rewrites four words; unused trailing words become 0000h.
// - Selected column driven high, columns 0 to 15, others high-Z.
// - Full scan of 16 columns takes about 4 ms in the example.
// - Whole scan and reply finish within the 20 ms reply window.
// - Scan stops at the column giving the fourth pressed column.
// - Next scan resumes after last column, wraps, stops at four or 16.
`timescale 1ns/100ps
`include "kms_defs.vh"

module kms_key_scanner #(
	parameter integer ACT_CYC_64 = `KMS_ACT_64_US * `KMS_CLK_MHZ,
	parameter integer ACT_CYC_128 = `KMS_ACT_128_US * `KMS_CLK_MHZ,
	parameter integer ACT_CYC_256 = `KMS_ACT_256_US * `KMS_CLK_MHZ,
	parameter integer ACT_CYC_512 = `KMS_ACT_512_US * `KMS_CLK_MHZ,
	parameter integer REPLY_CYC = `KMS_REPLY_WINDOW_MS * 1000 *
		`KMS_CLK_MHZ
) (
	// Clock and control
	input wire clock,
	input wire rst_n,
	input wire ce,
	input wire lowPowerReset,
	// Write command
	input wire wrReq,
	input wire [11:0] wrAddr,
	input wire [15:0] wrData,
	// BlockErase command
	input wire eraseReq,
	input wire [7:0] eraseOpcode,
	input wire [11:0] eraseAddr,
	input wire [7:0] eraseCount,
	// Read command
	input wire rdReq,
	input wire [7:0] rdOpcode,
	input wire [11:0] rdAddr,
	output reg rdValid,
	output reg rdHit,
	output reg [15:0] rdData,
	// BlockErase reply
	output reg replyValid,
	output reg replyErr,
	output reg [7:0] replyCode,
	output reg scanBusy,
	// Key matrix pins
	output reg [15:0] columnLineOut,
	output reg [15:0] columnLineOe_n,
	input wire [7:0] rowSenseBits,
	input wire supplyLow
);

	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_DRIVE = 3'b010;
	localparam [2:0] S_NEXT = 3'b100;

	reg [2:0] state_reg;
	reg [15:0] setting_reg;
	reg [15:0] result_reg [0:3];
	reg [3:0] resumeCol_reg;
	reg [3:0] column_drive_index_reg;
	reg [2:0] found_reg;
	reg [4:0] scanned_reg;
	reg [15:0] actCnt_reg;
	reg [20:0] windowCnt_reg;
	reg rowHit;
	reg [15:0] actLoad;

	wire [8:0] syncIn;
	wire [8:0] syncOut;
	wire [7:0] rowSync;
	wire supplyLowSync;
	wire scanEnable;
	wire [1:0] column_activate_time;
	wire [3:0] final_column_index;
	wire eraseHit;
	wire eraseGood;
	wire [3:0] nextCol;
	wire lastOfColumn;
	wire [2:0] foundNext;
	wire [4:0] scannedNext;
	wire windowOver;

	assign syncIn = {supplyLow, rowSenseBits};

	kms_input_sync #(
		.WIDTH(9)
	) uSync (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);

	assign rowSync = syncOut[7:0];
	assign supplyLowSync = syncOut[8];

	assign scanEnable = setting_reg[`KMS_SET_EN_BIT];
	assign column_activate_time =
		setting_reg[`KMS_SET_TIME_HI:`KMS_SET_TIME_LO];
	assign final_column_index =
		setting_reg[`KMS_SET_LAST_HI:`KMS_SET_LAST_LO];

	// Erase to the result block with the agreed word count
	assign eraseHit = eraseReq &&
		eraseOpcode == `KMS_OP_BLOCKERASE &&
		eraseAddr == `KMS_ADDR_RESULT0;
	assign eraseGood = scanEnable &&
		eraseCount == {4'h0, final_column_index} + 8'h01;

	// Column stepping wraps 15 to 0 by natural overflow
	assign nextCol = column_drive_index_reg + 4'h1;
	assign lastOfColumn = (actCnt_reg == 16'h0000);
	assign foundNext = found_reg + {2'b00, rowHit};
	assign scannedNext = scanned_reg + 5'd1;
	assign windowOver = (windowCnt_reg == 21'h000000);

	// Column window length from the time code
	always @* begin
		actLoad = ACT_CYC_256[15:0] - 16'h0001;
		case (column_activate_time)
			`KMS_TIME_CODE_256: actLoad = ACT_CYC_256[15:0] - 16'h0001;
			`KMS_TIME_CODE_512: actLoad = ACT_CYC_512[15:0] - 16'h0001;
			`KMS_TIME_CODE_64: actLoad = ACT_CYC_64[15:0] - 16'h0001;
			`KMS_TIME_CODE_128: actLoad = ACT_CYC_128[15:0] - 16'h0001;
			default: actLoad = ACT_CYC_256[15:0] - 16'h0001;
		endcase
	end

	always @* begin
		rowHit = (rowSync != 8'h00);
	end

	// Setting word and resume pointer
	always @(posedge clock) begin
		if (!rst_n) begin
			setting_reg <= `KMS_SET_RESET;
			resumeCol_reg <= 4'h0;
		end else if (ce) begin
			if (lowPowerReset) begin
				setting_reg <= `KMS_SET_RESET;
				resumeCol_reg <= 4'h0;
			end else if (wrReq && wrAddr == `KMS_ADDR_SETTING &&
				state_reg == S_IDLE) begin
				if (!wrData[`KMS_SET_EN_BIT]) begin
					setting_reg <= `KMS_SET_RESET;
					resumeCol_reg <= 4'h0;
				end else begin
					// Reserved bits are dropped so they steer nothing
					setting_reg <= wrData & `KMS_SET_KEEP_MASK;
				end
			end else if (state_reg == S_NEXT) begin
				resumeCol_reg <= nextCol;
			end
		end
	end

	// Scan sequencer
	always @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			column_drive_index_reg <= 4'h0;
			found_reg <= 3'd0;
			scanned_reg <= 5'd0;
			actCnt_reg <= 16'h0000;
			windowCnt_reg <= 21'h000000;
			replyValid <= 1'b0;
			replyErr <= 1'b0;
			replyCode <= `KMS_ERR_NONE;
			scanBusy <= 1'b0;
			columnLineOut <= 16'h0000;
			columnLineOe_n <= 16'hFFFF;
		end else if (ce) begin
			replyValid <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					columnLineOut <= 16'h0000;
					columnLineOe_n <= 16'hFFFF;
					if (eraseHit && !lowPowerReset) begin
						if (eraseGood) begin
							state_reg <= S_DRIVE;
							scanBusy <= 1'b1;
							column_drive_index_reg <= resumeCol_reg;
							found_reg <= 3'd0;
							scanned_reg <= 5'd0;
							actCnt_reg <= actLoad;
							windowCnt_reg <= REPLY_CYC[20:0] - 21'h000001;
						end else begin
							// Disabled or bad count: refused at once
							replyValid <= 1'b1;
							replyErr <= 1'b1;
							replyCode <= `KMS_ERR_OTHER;
						end
					end
				end
				S_DRIVE: begin
					columnLineOut <= 16'h0001 << column_drive_index_reg;
					// Only the selected column is driven high
					columnLineOe_n <= ~(16'h0001 << column_drive_index_reg);
					// Saturates so an expiry inside a column is not lost
					if (!windowOver) begin
						windowCnt_reg <= windowCnt_reg - 21'h000001;
					end
					if (supplyLowSync || lowPowerReset) begin
						state_reg <= S_IDLE;
						scanBusy <= 1'b0;
						replyValid <= 1'b1;
						replyErr <= 1'b1;
						replyCode <= `KMS_ERR_LOW_POWER;
						// Column released at once, not a cycle late
						columnLineOut <= 16'h0000;
						columnLineOe_n <= 16'hFFFF;
					end else if (lastOfColumn) begin
						found_reg <= foundNext;
						scanned_reg <= scannedNext;
						state_reg <= S_NEXT;
					end else if (windowOver) begin
						// Cut column: nothing stored, reply goes out next
						state_reg <= S_NEXT;
					end else begin
						actCnt_reg <= actCnt_reg - 16'h0001;
					end
				end
				S_NEXT: begin
					columnLineOut <= 16'h0000;
					columnLineOe_n <= 16'hFFFF;
					if (!windowOver) begin
						windowCnt_reg <= windowCnt_reg - 21'h000001;
					end
					// A drop in the gap aborts as in a column
					// Otherwise stop on fourth hit, 16 columns, or window
					if (supplyLowSync || lowPowerReset) begin
						state_reg <= S_IDLE;
						scanBusy <= 1'b0;
						replyValid <= 1'b1;
						replyErr <= 1'b1;
						replyCode <= `KMS_ERR_LOW_POWER;
					end else if (found_reg == `KMS_MAX_FOUND ||
						scanned_reg == `KMS_MAX_COLUMNS || windowOver) begin
						state_reg <= S_IDLE;
						scanBusy <= 1'b0;
						replyValid <= 1'b1;
						if (found_reg == 3'd0) begin
							replyErr <= 1'b1;
							replyCode <= `KMS_ERR_NO_KEY;
						end else begin
							replyErr <= 1'b0;
							replyCode <= `KMS_ERR_NONE;
						end
					end else begin
						column_drive_index_reg <= nextCol;
						actCnt_reg <= actLoad;
						state_reg <= S_DRIVE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
					scanBusy <= 1'b0;
					columnLineOut <= 16'h0000;
					columnLineOe_n <= 16'hFFFF;
				end
			endcase
		end
	end

	// Result words, one per slot
	genvar w;
	generate
		for (w = 0; w < 4; w = w + 1) begin : gResult
			always @(posedge clock) begin
				if (!rst_n) begin
					result_reg[w] <= `KMS_RES_RESET;
				end else if (ce) begin
					if (state_reg == S_IDLE && eraseHit && eraseGood &&
						!lowPowerReset) begin
						// Cleared up front so unfilled words stay zero
						result_reg[w] <= `KMS_RES_RESET;
					end else if (state_reg == S_DRIVE && lastOfColumn &&
						!supplyLowSync && !lowPowerReset && rowHit &&
						found_reg == w) begin
						result_reg[w] <= {4'h0, column_drive_index_reg,
							rowSync};
					end
				end
			end
		end
	endgenerate

	// Read port, answers one cycle after the request
	always @(posedge clock) begin
		if (!rst_n) begin
			rdValid <= 1'b0;
			rdHit <= 1'b0;
			rdData <= 16'h0000;
		end else if (ce) begin
			rdValid <= rdReq;
			rdHit <= 1'b0;
			rdData <= 16'h0000;
			if (rdReq && rdOpcode == `KMS_OP_READ) begin
				case (rdAddr)
					`KMS_ADDR_SETTING: begin
						rdHit <= 1'b1;
						rdData <= setting_reg;
					end
					`KMS_ADDR_RESULT0: begin
						rdHit <= 1'b1;
						rdData <= result_reg[0];
					end
					`KMS_ADDR_RESULT1: begin
						rdHit <= 1'b1;
						rdData <= result_reg[1];
					end
					`KMS_ADDR_RESULT2: begin
						rdHit <= 1'b1;
						rdData <= result_reg[2];
					end
					`KMS_ADDR_RESULT3: begin
						rdHit <= 1'b1;
						rdData <= result_reg[3];
					end
					default: begin
						rdHit <= 1'b0;
						rdData <= 16'h0000;
					end
				endcase
			end
		end
	end

endmodule // kms_key_scanner

// *** kms_checker.sv ***
// Purpose: port checks for the key scanner
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every scanner instance
`timescale 1ns/100ps
module kms_checker #(
	parameter integer REPLY_CYC = 2000
) (
	// Clock and control
	input wire clock,
	input wire rst_n,
	input wire ce,
	input wire lowPowerReset,
	// Read
	input wire rdReq,
	input wire rdValid,
	input wire rdHit,
	input wire [15:0] rdData,
	// Reply
	input wire replyValid,
	input wire replyErr,
	input wire [7:0] replyCode,
	input wire scanBusy,
	// Columns
	input wire [15:0] columnLineOut,
	input wire [15:0] columnLineOe_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	reg [20:0] busyCnt;
	// Counter, since the window is far beyond a repetition
	always @(posedge clock) begin
		if (!rst_n || !scanBusy)
			busyCnt <= 21'h0;
		else if (ce)
			busyCnt <= busyCnt + 21'h1;
	end
	a_reset_idle: assert property ($rose(rst_n) |->
		columnLineOe_n == 16'hFFFF && !scanBusy && !replyValid)
		else $error("outputs not idle after reset");
	a_read_answer: assert property (rdReq && ce |=> rdValid)
		else $error("read not answered");
	a_refused_zero: assert property (rdValid && !rdHit |->
		rdData == 16'h0000) else $error("refused read data");
	a_idle_hiz: assert property (!scanBusy && !$past(scanBusy) |->
		columnLineOe_n == 16'hFFFF) else $error("column driven idle");
	a_drive_high: assert property ($onehot0(~columnLineOe_n) &&
		(columnLineOut & ~columnLineOe_n) == ~columnLineOe_n)
		else $error("bad column drive");
	a_reply_end: assert property ($fell(scanBusy) |-> replyValid)
		else $error("scan ended without reply");
	a_reply_pulse: assert property (replyValid && ce |=> !replyValid)
		else $error("reply too long");
	a_err_code: assert property (replyValid && replyCode != 8'h00
		|-> replyErr) else $error("error code without flag");
	a_low_power: assert property (lowPowerReset &&
		columnLineOe_n != 16'hFFFF && $past(columnLineOe_n) != 16'hFFFF
		|=> replyValid && replyCode == 8'h0B) else $error("no abort");
	a_busy_bound: assert property (busyCnt < REPLY_CYC + 3)
		else $error("scan exceeds reply window");
	c_no_key: cover property (replyValid && replyCode == 8'h8E);
	c_found: cover property (replyValid && !replyErr);
	c_abort: cover property (replyValid && replyCode == 8'h0B);
endmodule // kms_checker

bind kms_key_scanner kms_checker #(.REPLY_CYC(REPLY_CYC)) chk_u (
	.clock(clock), .rst_n(rst_n), .ce(ce), .lowPowerReset(lowPowerReset),
	.rdReq(rdReq), .rdValid(rdValid), .rdHit(rdHit), .rdData(rdData),
	.replyValid(replyValid), .replyErr(replyErr), .replyCode(replyCode),
	.scanBusy(scanBusy), .columnLineOut(columnLineOut),
	.columnLineOe_n(columnLineOe_n));

// *** kms_matrix_model.sv ***
// Purpose: key matrix seen from the scanner pins
// Assumes: rows pulled down, keys close column to row
// Notes: a Hi-Z column reaches no row
`timescale 1ns/100ps
module kms_matrix_model (
	// Column lines
	input wire [15:0] columnLineOut,
	input wire [15:0] columnLineOe_n,
	// Pressed rows of column c at bits 8c+7:8c
	input wire [127:0] keyMap,
	// Row lines
	output reg [7:0] rowSenseBits
);
	integer c;
	always @* begin
		rowSenseBits = 8'h00;
		for (c = 0; c < 16; c = c + 1) begin
			if (!columnLineOe_n[c] && columnLineOut[c])
				rowSenseBits = rowSenseBits | keyMap[8*c +: 8];
		end
	end
endmodule // kms_matrix_model

// *** tb_top.sv ***
// Purpose: self-checking bench for the key scanner
// Assumes: short activate counts 16, 24, 8, 12 cycles
// Notes: inputs change by non-blocking assignment, except clock and keyMap, which use blocking assignment
`timescale 1ns/100ps
module tb_top;
	reg clock = 1'b0;
	reg rst_n = 1'b0;
	reg ce = 1'b1;
	reg [7:0] eraseOpcode = 8'hC8;
	reg [11:0] eraseAddr = 12'hF10;
	reg lowPowerReset = 1'b0;
	reg supplyLow = 1'b0;
	reg wrReq = 1'b0;
	reg [11:0] wrAddr = 12'h000;
	reg [15:0] wrData = 16'h0000;
	reg eraseReq = 1'b0;
	reg [7:0] eraseCount = 8'h00;
	reg rdReq = 1'b0;
	reg [7:0] rdOpcode = 8'h00;
	reg [11:0] rdAddr = 12'h000;
	reg [127:0] keyMap = 128'h0;
	wire rdValid, rdHit, replyValid, replyErr, scanBusy;
	wire [15:0] rdData, columnLineOut, columnLineOe_n;
	wire [7:0] replyCode, rowSenseBits;
	integer error_cnt = 0;
	integer check_count = 0;
	integer width, i, c;
	initial forever #5 clock = ~clock;
	kms_key_scanner #(.ACT_CYC_64(8), .ACT_CYC_128(12), .ACT_CYC_256(16),
		.ACT_CYC_512(24), .REPLY_CYC(2000)) dut_u (
		.clock(clock), .rst_n(rst_n), .ce(ce),
		.lowPowerReset(lowPowerReset), .wrReq(wrReq), .wrAddr(wrAddr),
		.wrData(wrData), .eraseReq(eraseReq), .eraseOpcode(eraseOpcode),
		.eraseAddr(eraseAddr), .eraseCount(eraseCount), .rdReq(rdReq),
		.rdOpcode(rdOpcode), .rdAddr(rdAddr), .rdValid(rdValid),
		.rdHit(rdHit), .rdData(rdData), .replyValid(replyValid),
		.replyErr(replyErr), .replyCode(replyCode), .scanBusy(scanBusy),
		.columnLineOut(columnLineOut), .columnLineOe_n(columnLineOe_n),
		.rowSenseBits(rowSenseBits), .supplyLow(supplyLow));
	kms_matrix_model model_u (.columnLineOut(columnLineOut),
		.columnLineOe_n(columnLineOe_n), .keyMap(keyMap),
		.rowSenseBits(rowSenseBits));
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t got %h want %h", $time, seen, exp);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task wrWord(input [11:0] a, input [15:0] d);
		begin
			@(posedge clock);
			wrReq <= 1'b1;
			wrAddr <= a;
			wrData <= d;
			@(posedge clock);
			wrReq <= 1'b0;
		end
	endtask
	task rdWord(input [7:0] op, input [11:0] a, input h, input [15:0] d);
		begin
			@(posedge clock);
			rdReq <= 1'b1;
			rdOpcode <= op;
			rdAddr <= a;
			@(posedge clock);
			rdReq <= 1'b0;
			#1;
			chk({15'h0, rdValid}, 16'h0001);
			chk({15'h0, rdHit}, {15'h0, h});
			chk(rdData, d);
		end
	endtask
	task rdRes(input [15:0] w0, input [15:0] w1, input [15:0] w2,
		input [15:0] w3);
		begin
			rdWord(8'hC2, 12'hF10, 1'b1, w0);
			rdWord(8'hC2, 12'hF11, 1'b1, w1);
			rdWord(8'hC2, 12'hF12, 1'b1, w2);
			rdWord(8'hC2, 12'hF13, 1'b1, w3);
		end
	endtask
	task startErase(input [7:0] n);
		begin
			@(posedge clock);
			eraseReq <= 1'b1;
			eraseCount <= n;
			@(posedge clock);
			eraseReq <= 1'b0;
		end
	endtask
	// Wrong opcode or address must start nothing and answer nothing
	task badErase(input [7:0] op, input [11:0] a);
		begin
			@(posedge clock);
			eraseReq <= 1'b1;
			eraseOpcode <= op;
			eraseAddr <= a;
			eraseCount <= 8'h10;
			@(posedge clock);
			eraseReq <= 1'b0;
			eraseOpcode <= 8'hC8;
			eraseAddr <= 12'hF10;
			#1;
			chk({15'h0, scanBusy}, 16'h0000);
			chk({15'h0, replyValid}, 16'h0000);
		end
	endtask
	// Width counts cycles with column 0 driven
	task waitReply(input e, input [7:0] code);
		begin
			width = 0;
			i = 0;
			#1;
			while (replyValid !== 1'b1 && i < 4000) begin
				if (columnLineOe_n[0] === 1'b0)
					width = width + 1;
				@(posedge clock);
				#1;
				i = i + 1;
			end
			if (i == 4000) begin
				error_cnt = error_cnt + 1;
				print_verdict;
			end
			chk({15'h0, replyErr}, {15'h0, e});
			chk({8'h0, replyCode}, {8'h0, code});
		end
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rdWord(8'hC2, 12'hF01, 1'b1, 16'h0000);
		rdRes(16'h0, 16'h0, 16'h0, 16'h0);
		rdWord(8'hC2, 12'hF02, 1'b0, 16'h0000);
		rdWord(8'h00, 12'hF10, 1'b0, 16'h0000);
		startErase(8'h10);
		waitReply(1'b1, 8'h00);
		wrWord(12'hF01, 16'hDFFF);
		rdWord(8'hC2, 12'hF01, 1'b1, 16'hC0F0);
		@(posedge clock);
		ce <= 1'b0;
		wrWord(12'hF01, 16'h8000);
		ce <= 1'b1;
		rdWord(8'hC2, 12'hF01, 1'b1, 16'hC0F0);
		badErase(8'hC2, 12'hF10);
		badErase(8'hC8, 12'hF11);
		startErase(8'h05);
		waitReply(1'b1, 8'h00);
		startErase(8'h10);
		waitReply(1'b1, 8'h8E);
		chk(i[15:0], 16'h0090);
		rdRes(16'h0, 16'h0, 16'h0, 16'h0);
		keyMap = 128'h4000_0000_0001_0000_0000_0030_0000_0280;
		startErase(8'h10);
		waitReply(1'b0, 8'h00);
		rdRes(16'h0080, 16'h0102, 16'h0430, 16'h0A01);
		startErase(8'h10);
		waitReply(1'b0, 8'h00);
		rdRes(16'h0F40, 16'h0080, 16'h0102, 16'h0430);
		keyMap = 128'h0001_0000;
		startErase(8'h10);
		waitReply(1'b0, 8'h00);
		rdRes(16'h0201, 16'h0, 16'h0, 16'h0);
		keyMap = 128'h0000_0001_0000_0001_0100_0000_0100_0100;
		for (c = 0; c < 4; c = c + 1) begin
			wrWord(12'hF01, 16'h0000);
			rdWord(8'hC2, 12'hF01, 1'b1, 16'h0000);
			wrWord(12'hF01, {1'b1, c[1:0], 9'h00F, 4'h0});
			startErase(8'h10);
			waitReply(1'b0, 8'h00);
			chk(width[15:0], c == 0 ? 16 : c == 1 ? 24 : c == 2 ? 8 : 12);
			rdRes(16'h0101, 16'h0301, 16'h0701, 16'h0801);
		end
		startErase(8'h10);
		repeat (4) @(posedge clock);
		lowPowerReset <= 1'b1;
		@(posedge clock);
		lowPowerReset <= 1'b0;
		waitReply(1'b1, 8'h0B);
		rdWord(8'hC2, 12'hF01, 1'b1, 16'h0000);
		wrWord(12'hF01, 16'hE0F0);
		startErase(8'h10);
		repeat (3) @(posedge clock);
		supplyLow <= 1'b1;
		waitReply(1'b1, 8'h0B);
		@(posedge clock);
		supplyLow <= 1'b0;
		print_verdict;
	end
endmodule // tb_top
